// >>> logic/hesc_pkg.sv
// Constants, register map and state type for the horizontal eye-scan controller.
// Assumes a single pclk domain shared with the recovery datapath and an APB master.
// How it works
// - Each unit interval is split into 256 scan positions, whatever the oversampling.
// - Zero exploring phases removes scan logic; one phase sweeps -128 to 127.
// - Two phases: phase zero sweeps 0 to 127, phase one -1 to -128.
// - In automatic mode the controller runs the sweep; a start request launches it.
// - Busy stays high from sweep start until all 256 positions are measured.
// - Each position is held for the programmed dwell cycles while errors accumulate.
// - A valid flag marks each phase tally as usable; sample tallies only then.
// - Repeat select zero gives one sweep, any other value sweeps continuously.
// - The last measured eye aperture is reported in steps of 1/256 UI.
// - Sample-point offset is two's complement; zero samples at eye centre.
// - Scan positions are relative to eye centre, never to the sampling offset.
// - Precision follows the mask: sixteen ones give 16 bits, low bit cleared 15.
// - A start request arriving while busy is dropped.
// - The aperture result is refreshed each time busy falls.
`default_nettype none
package hesc_pkg;
	localparam int HESC_POS_W = 8;
	localparam int HESC_APER_W = 9;
	localparam int HESC_PREC_W = 5;
	localparam int HESC_MASK_W = 16;
	localparam int HESC_ADDR_W = 8;

	localparam logic [HESC_ADDR_W-1:0] HESC_OFF_CTRL = 8'h00;
	localparam logic [HESC_ADDR_W-1:0] HESC_OFF_DWELL = 8'h04;
	localparam logic [HESC_ADDR_W-1:0] HESC_OFF_MANUAL = 8'h08;
	localparam logic [HESC_ADDR_W-1:0] HESC_OFF_TUNE = 8'h0C;
	localparam logic [HESC_ADDR_W-1:0] HESC_OFF_STATUS = 8'h10;
	localparam logic [HESC_ADDR_W-1:0] HESC_OFF_TALLY0 = 8'h14;
	localparam logic [HESC_ADDR_W-1:0] HESC_OFF_TALLY1 = 8'h18;
	localparam logic [HESC_ADDR_W-1:0] HESC_OFF_SCANPOS = 8'h1C;

	localparam int HESC_CTRL_AUTO = 0;
	localparam int HESC_CTRL_REP_LSB = 1;
	localparam int HESC_CTRL_REP_MSB = 2;
	localparam int HESC_CTRL_START = 3;
	localparam int HESC_MAN_P1_LSB = 8;
	localparam int HESC_TUNE_MASK_LSB = 16;
	localparam int HESC_ST_BUSY = 0;
	localparam int HESC_ST_VAL0 = 1;
	localparam int HESC_ST_VAL1 = 2;
	localparam int HESC_ST_APER_LSB = 8;
	localparam int HESC_POS1_LSB = 8;

	localparam logic [31:0] HESC_DWELL_RST = 32'h0000_0400;
	localparam logic [HESC_MASK_W-1:0] HESC_MASK_RST = 16'hFFFF;
	localparam logic [HESC_POS_W-1:0] HESC_HALF_FLIP = 8'h80;
	localparam logic [HESC_POS_W-1:0] HESC_LAST_ONE = 8'hFF;
	localparam logic [HESC_POS_W-1:0] HESC_LAST_TWO = 8'h7F;
	localparam logic [HESC_PREC_W-1:0] HESC_PREC_FULL = 5'h10;
	localparam logic [HESC_PREC_W-1:0] HESC_PREC_LESS = 5'h0F;

	typedef enum logic [3:0] {
		HESC_R_CTRL, HESC_R_DWELL, HESC_R_MANUAL, HESC_R_TUNE,
		HESC_R_STATUS, HESC_R_TALLY0, HESC_R_TALLY1, HESC_R_SCANPOS, HESC_R_NONE
	} hesc_reg_t;

	typedef enum {HESC_IDLE, HESC_RUN, HESC_DONE} hesc_state_t;
endpackage
`default_nettype wire

// >>> logic/hesc_tally_if.sv
// Bundle between the scan sequencer and one per-phase error tally unit.
// Assumes both ends run on pclk.
`default_nettype none
interface hesc_tally_if #(parameter int TW = 7);
	logic window_end;
	logic restart;
	logic mismatch;
	logic clean;
	logic [TW-1:0] tally;
	logic valid;
	modport ctrl (output window_end, restart, mismatch, input clean, tally, valid);
	modport unit (input window_end, restart, mismatch, output clean, tally, valid);
endinterface
`default_nettype wire

// >>> logic/hesc_tally.sv
// Per-phase error tally: counts disagreeing cycles over one dwell window.
// Assumes window_end and restart come from the sequencer on pclk.
`default_nettype none
module hesc_tally #(
	parameter int TW = 7
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sequencer side
	hesc_tally_if.unit tif
);
	import hesc_pkg::*;

	localparam logic [TW-1:0] TMAX = '1;
	logic [TW-1:0] cnt_q, cnt_d, cnt_inc, tally_q;
	logic valid_q;

	// Saturate so a long dwell never wraps back to a clean-looking value
	assign cnt_inc = (cnt_q == TMAX) ? cnt_q : cnt_q + 1'b1;
	assign tif.clean = (cnt_q == '0) && !tif.mismatch;

	always_comb begin
		cnt_d = cnt_q;
		if (tif.window_end || tif.restart) begin
			cnt_d = '0;
		end else if (tif.mismatch) begin
			cnt_d = cnt_inc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tally_q <= '0;
			valid_q <= 1'b0;
		end else begin
			valid_q <= tif.window_end;
			if (tif.window_end) begin
				tally_q <= tif.mismatch ? cnt_inc : cnt_q;
			end
		end
	end

	assign tif.tally = tally_q;
	assign tif.valid = valid_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_TALLY_HOLD: assert property (!tif.window_end |=> $stable(tally_q))
		else $error("tally changed outside a window end");
	AST_VALID_CAUSE: assert property (valid_q |-> $past(tif.window_end))
		else $error("tally valid without a window end");
	AST_CLEAN_WINDOW: assert property (tif.window_end && tif.clean |=> tally_q == '0)
		else $error("clean window gave nonzero tally");
endmodule
`default_nettype wire

// >>> logic/hesc_top.sv
// Horizontal eye-scan controller with APB register access.
// Assumes the recovery datapath on pclk supplies sampled bits and applies positions.
`default_nettype none
module hesc_top #(
	parameter int EXPLORE_PHASES = 2,
	parameter int TALLY_W = 7,
	parameter int DWELL_W = 32
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [hesc_pkg::HESC_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Recovery datapath
	input wire logic data_bit,
	input wire logic [1:0] explore_bit,
	output logic [hesc_pkg::HESC_POS_W-1:0] phase0_scan_pos,
	output logic [hesc_pkg::HESC_POS_W-1:0] phase1_scan_pos,
	output logic [hesc_pkg::HESC_POS_W-1:0] sample_point_offset,
	output logic [hesc_pkg::HESC_MASK_W-1:0] precision_mask,
	output logic [hesc_pkg::HESC_PREC_W-1:0] calc_precision,
	// Scan results
	output logic scan_busy,
	output logic [hesc_pkg::HESC_APER_W-1:0] aperture_result,
	output logic [TALLY_W-1:0] phase0_error_tally,
	output logic [TALLY_W-1:0] phase1_error_tally,
	output logic [1:0] error_tally_valid
);
	import hesc_pkg::*;

	localparam bit SCAN_ON = (EXPLORE_PHASES != 0);
	localparam logic [HESC_POS_W-1:0] LAST_STEP =
		(EXPLORE_PHASES == 2) ? HESC_LAST_TWO : HESC_LAST_ONE;

	function automatic hesc_reg_t hesc_decode(input logic [HESC_ADDR_W-1:0] a);
		case (a)
			HESC_OFF_CTRL: hesc_decode = HESC_R_CTRL;
			HESC_OFF_DWELL: hesc_decode = HESC_R_DWELL;
			HESC_OFF_MANUAL: hesc_decode = HESC_R_MANUAL;
			HESC_OFF_TUNE: hesc_decode = HESC_R_TUNE;
			HESC_OFF_STATUS: hesc_decode = HESC_R_STATUS;
			HESC_OFF_TALLY0: hesc_decode = HESC_R_TALLY0;
			HESC_OFF_TALLY1: hesc_decode = HESC_R_TALLY1;
			HESC_OFF_SCANPOS: hesc_decode = HESC_R_SCANPOS;
			default: hesc_decode = HESC_R_NONE;
		endcase
	endfunction

	function automatic logic [HESC_PREC_W-1:0] hesc_ones(input logic [HESC_MASK_W-1:0] m);
		logic [HESC_PREC_W-1:0] n;
		n = '0;
		for (int i = 0; i < HESC_MASK_W; i++) begin
			n = n + {{(HESC_PREC_W-1){1'b0}}, m[i]};
		end
		hesc_ones = n;
	endfunction

	hesc_reg_t sel;
	logic wr_en, rd_setup, start_req, start_accept;
	logic auto_q, start_seen;
	logic [1:0] repeat_q;
	logic [DWELL_W-1:0] dwell_q, dwell_lim, dwell_cnt_q;
	logic [HESC_POS_W-1:0] man0_q, man1_q, offset_q, step_q;
	logic [HESC_POS_W-1:0] pos0_d, pos1_d, pos0_q, pos1_q;
	logic [HESC_MASK_W-1:0] mask_q;
	logic [HESC_PREC_W-1:0] prec_q;
	logic [HESC_APER_W-1:0] acc_q, acc_next, aper_q;
	logic [31:0] rdata_d, prdata_q;
	logic window_end, restart;
	logic [1:0] clean;
	logic [TALLY_W-1:0] tally [2];
	logic [1:0] tvalid;
	hesc_state_t state_q;

	// Zero-wait slave: every access completes in its first access cycle
	assign sel = hesc_decode(paddr);
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (sel == HESC_R_NONE);

	assign start_req = wr_en && (sel == HESC_R_CTRL) && pwdata[HESC_CTRL_START];
	// Requests while busy are simply dropped, there is no queue
	assign start_accept = SCAN_ON && start_req && pwdata[HESC_CTRL_AUTO] &&
		(state_q == HESC_IDLE);
	assign start_seen = start_req && !start_accept;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_q <= 1'b0;
			repeat_q <= '0;
			dwell_q <= DWELL_W'(HESC_DWELL_RST);
			man0_q <= '0;
			man1_q <= '0;
			offset_q <= '0;
			mask_q <= HESC_MASK_RST;
		end else if (wr_en) begin
			case (sel)
				HESC_R_CTRL: begin
					auto_q <= pwdata[HESC_CTRL_AUTO];
					repeat_q <= pwdata[HESC_CTRL_REP_MSB:HESC_CTRL_REP_LSB];
				end
				HESC_R_DWELL: dwell_q <= pwdata[DWELL_W-1:0];
				HESC_R_MANUAL: begin
					man0_q <= pwdata[HESC_POS_W-1:0];
					man1_q <= pwdata[HESC_MAN_P1_LSB +: HESC_POS_W];
				end
				HESC_R_TUNE: begin
					offset_q <= pwdata[HESC_POS_W-1:0];
					mask_q <= pwdata[HESC_TUNE_MASK_LSB +: HESC_MASK_W];
				end
				default: begin
				end
			endcase
		end
	end

	// Offset is passed through untouched; the datapath treats it as signed
	assign sample_point_offset = offset_q;
	assign precision_mask = mask_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prec_q <= HESC_PREC_FULL;
		end else begin
			prec_q <= hesc_ones(mask_q);
		end
	end
	assign calc_precision = prec_q;

	// Dwell timing; a zero setting is treated as one cycle per position
	assign dwell_lim = (dwell_q == '0) ? DWELL_W'(1) : dwell_q;
	assign window_end = (dwell_cnt_q == dwell_lim - 1'b1);
	assign restart = start_accept || (state_q == HESC_DONE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dwell_cnt_q <= '0;
		end else if (window_end || restart) begin
			dwell_cnt_q <= '0;
		end else begin
			dwell_cnt_q <= dwell_cnt_q + 1'b1;
		end
	end

	assign acc_next = acc_q + HESC_APER_W'(clean[0]) + HESC_APER_W'(clean[1]);

	// Sweep sequencer: one step per dwell window, 256 positions in total
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= HESC_IDLE;
			step_q <= '0;
			acc_q <= '0;
			aper_q <= '0;
		end else begin
			case (state_q)
				HESC_IDLE: begin
					if (start_accept) begin
						state_q <= HESC_RUN;
						step_q <= '0;
						acc_q <= '0;
					end
				end
				HESC_RUN: begin
					if (window_end) begin
						if (step_q == LAST_STEP) begin
							state_q <= HESC_DONE;
							step_q <= '0;
							acc_q <= '0;
							aper_q <= acc_next;
						end else begin
							step_q <= step_q + 1'b1;
							acc_q <= acc_next;
						end
					end
				end
				HESC_DONE: begin
					// Busy drops for this one cycle even when repeating, so the
					// aperture refresh stays visible on every sweep
					if (auto_q && (repeat_q != '0)) begin
						state_q <= HESC_RUN;
					end else begin
						state_q <= HESC_IDLE;
					end
				end
				default: state_q <= HESC_IDLE;
			endcase
		end
	end

	assign scan_busy = (state_q == HESC_RUN);
	assign aperture_result = aper_q;

	// Positions are centre-referenced; the sampling offset never enters here
	always_comb begin
		pos0_d = man0_q;
		pos1_d = man1_q;
		if (state_q == HESC_RUN) begin
			if (EXPLORE_PHASES == 2) begin
				pos0_d = step_q;
				pos1_d = ~step_q;
			end else begin
				pos0_d = step_q ^ HESC_HALF_FLIP;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos0_q <= '0;
			pos1_q <= '0;
		end else begin
			pos0_q <= pos0_d;
			pos1_q <= pos1_d;
		end
	end
	assign phase0_scan_pos = pos0_q;
	assign phase1_scan_pos = pos1_q;

	hesc_tally_if #(.TW(TALLY_W)) tif [2] ();

	generate
		for (genvar i = 0; i < 2; i++) begin : g_phase
			if (i < EXPLORE_PHASES) begin : g_on
				assign tif[i].window_end = window_end;
				assign tif[i].restart = restart;
				assign tif[i].mismatch = explore_bit[i] ^ data_bit;
				assign clean[i] = tif[i].clean;
				assign tally[i] = tif[i].tally;
				assign tvalid[i] = tif[i].valid;
				hesc_tally #(.TW(TALLY_W)) u_tally (
					.pclk(pclk),
					.presetn(presetn),
					.tif(tif[i])
				);
			end else begin : g_off
				assign tif[i].window_end = 1'b0;
				assign tif[i].restart = 1'b0;
				assign tif[i].mismatch = 1'b0;
				assign tif[i].clean = 1'b0;
				assign tif[i].tally = '0;
				assign tif[i].valid = 1'b0;
				assign clean[i] = 1'b0;
				assign tally[i] = '0;
				assign tvalid[i] = 1'b0;
			end
		end
	endgenerate

	assign phase0_error_tally = tally[0];
	assign phase1_error_tally = tally[1];
	assign error_tally_valid = tvalid;

	always_comb begin
		rdata_d = '0;
		case (sel)
			HESC_R_CTRL: begin
				rdata_d[HESC_CTRL_AUTO] = auto_q;
				rdata_d[HESC_CTRL_REP_MSB:HESC_CTRL_REP_LSB] = repeat_q;
			end
			HESC_R_DWELL: rdata_d[DWELL_W-1:0] = dwell_q;
			HESC_R_MANUAL: begin
				rdata_d[HESC_POS_W-1:0] = man0_q;
				rdata_d[HESC_MAN_P1_LSB +: HESC_POS_W] = man1_q;
			end
			HESC_R_TUNE: begin
				rdata_d[HESC_POS_W-1:0] = offset_q;
				rdata_d[HESC_TUNE_MASK_LSB +: HESC_MASK_W] = mask_q;
			end
			HESC_R_STATUS: begin
				rdata_d[HESC_ST_BUSY] = scan_busy;
				rdata_d[HESC_ST_VAL0] = tvalid[0];
				rdata_d[HESC_ST_VAL1] = tvalid[1];
				rdata_d[HESC_ST_APER_LSB +: HESC_APER_W] = aper_q;
			end
			HESC_R_TALLY0: rdata_d[TALLY_W-1:0] = tally[0];
			HESC_R_TALLY1: rdata_d[TALLY_W-1:0] = tally[1];
			HESC_R_SCANPOS: begin
				rdata_d[HESC_POS_W-1:0] = pos0_q;
				rdata_d[HESC_POS1_LSB +: HESC_POS_W] = pos1_q;
			end
			default: rdata_d = '0;
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (rd_setup) begin
			prdata_q <= rdata_d;
		end
	end
	assign prdata = prdata_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_START_BUSY: assert property (start_accept |=> scan_busy)
		else $error("accepted start did not raise busy");
	// A dropped start in the very last busy cycle must not be blamed for busy falling
	AST_DROP_BUSY: assert property (start_seen && scan_busy
		&& !(window_end && step_q == LAST_STEP) |=> scan_busy && $stable(aper_q))
		else $error("start while busy disturbed the sweep");
	AST_APER_FALL: assert property ($fell(scan_busy) |-> aper_q == $past(acc_next))
		else $error("aperture not refreshed when busy fell");
	AST_APER_HOLD: assert property (scan_busy |=> $stable(aper_q) || $fell(scan_busy))
		else $error("aperture changed mid sweep");
	AST_SINGLE: assert property ($fell(scan_busy) && repeat_q == '0 |=> !scan_busy)
		else $error("single sweep restarted");
	AST_REPEAT: assert property ($fell(scan_busy) && auto_q && repeat_q != '0 |=> scan_busy)
		else $error("continuous sweep did not restart");
	AST_TWO_HALVES: assert property (scan_busy && EXPLORE_PHASES == 2
		|=> pos1_q == ~pos0_q && !pos0_q[HESC_POS_W-1])
		else $error("two-phase positions not on opposite halves");
	AST_ONE_START: assert property (start_accept && EXPLORE_PHASES == 1
		|=> ##1 pos0_q == HESC_HALF_FLIP)
		else $error("single-phase sweep did not begin at -128");
	AST_BUSY_END: assert property (scan_busy && window_end && step_q == LAST_STEP
		|=> !scan_busy)
		else $error("busy outlived the last position");
	AST_DWELL_LEN: assert property (window_end && !restart |=> !window_end [*1] or
		dwell_lim == DWELL_W'(1))
		else $error("dwell window shorter than programmed");
	AST_PREC: assert property (mask_q == HESC_MASK_RST |=> prec_q == HESC_PREC_FULL)
		else $error("full mask did not give full precision");
	AST_PREC_LOW: assert property (mask_q == (HESC_MASK_RST ^ HESC_MASK_W'(1))
		|=> prec_q == HESC_PREC_LESS)
		else $error("cleared low bit did not drop one bit");

	COV_SWEEP: cover property (start_accept ##[1:1000] $fell(scan_busy));
	COV_REPEAT: cover property ($fell(scan_busy) ##1 $rose(scan_busy));
	COV_DROPPED: cover property (start_seen && scan_busy);
	COV_VALID: cover property (tvalid[0] && scan_busy);
endmodule
`default_nettype wire

// >>> tb/hesc_dp_model.sv
// Recovery datapath stand-in: a data stream, and exploring samples that disagree outside the eye.
// Assumes signed positions centred on the eye, all on pclk.
`default_nettype none
module hesc_dp_model #(
	parameter int EYE = 40
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Positions from the controller
	input wire logic [7:0] pos0,
	input wire logic [7:0] pos1,
	// Forces every exploring sample to disagree
	input wire logic noisy,
	// Sampled bits
	output logic data_bit,
	output logic [1:0] explore_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] lfsr_q;
	logic bad0;
	logic bad1;
	// A changing pattern, so a stuck comparison cannot pass for agreement
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_q <= 7'h01;
		end else begin
			lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
		end
	end
	// Eye edges fixed around centre; the data sampling offset never moves them
	assign bad0 = ($signed(pos0) >= EYE) || ($signed(pos0) < -EYE);
	assign bad1 = ($signed(pos1) >= EYE) || ($signed(pos1) < -EYE);
	// One data bit per cycle, so a per-cycle sample limit of one suffices
	// and the scan sample limit the model assumes is that limit plus one
	assign data_bit = lfsr_q[0];
	assign explore_bit = {data_bit ^ (noisy | bad1), data_bit ^ (noisy | bad0)};
endmodule
`default_nettype wire

// >>> tb/hesc_top_tb.sv
// Self-checking bench for the eye-scan controller: APB master, sweep monitor, datapath model.
// Assumes the package register map and a zero-wait APB slave.
`default_nettype none
module hesc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hesc_pkg::*;
	localparam int D = 4;
	localparam int EYE = 40;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} hesc_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, noisy = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, data_bit, scan_busy, er;
	logic [1:0] explore_bit, error_tally_valid;
	logic [7:0] phase0_scan_pos, phase1_scan_pos, sample_point_offset;
	logic [15:0] precision_mask;
	logic [4:0] calc_precision;
	logic [8:0] aperture_result;
	logic [6:0] phase0_error_tally, phase1_error_tally;
	logic signed [7:0] mn0, mx0, mn1, mx1;
	int fail_count = 0, comparisons = 0, cycles = 0, blen = 0, glen = 0, k;
	int lens[$], gaps[$];
	hesc_row_t rows [4] = '{'{HESC_OFF_DWELL, 32'h0000_0004, 32'h0000_0004},
		'{HESC_OFF_MANUAL, 32'h0000_FF00, 32'h0000_FF00},
		'{HESC_OFF_TUNE, 32'hFFFE_00F6, 32'hFFFE_00F6},
		'{HESC_OFF_CTRL, 32'h0000_0007, 32'h0000_0007}};

	hesc_top hesc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .data_bit(data_bit), .explore_bit(explore_bit),
		.phase0_scan_pos(phase0_scan_pos), .phase1_scan_pos(phase1_scan_pos),
		.sample_point_offset(sample_point_offset), .precision_mask(precision_mask),
		.calc_precision(calc_precision), .scan_busy(scan_busy),
		.aperture_result(aperture_result), .phase0_error_tally(phase0_error_tally),
		.phase1_error_tally(phase1_error_tally), .error_tally_valid(error_tally_valid));
	hesc_dp_model #(.EYE(EYE)) hesc_dp_model_i (.pclk(pclk), .presetn(presetn),
		.pos0(phase0_scan_pos), .pos1(phase1_scan_pos), .noisy(noisy),
		.data_bit(data_bit), .explore_bit(explore_bit));

	always #25 pclk = ~pclk;

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Request held from setup until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		chk({31'h0, pready}, 32'h0000_0001);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits until both valid flags are high, giving up after 1000 cycles
	task automatic wait_valid();
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (error_tally_valid !== 2'b11 && n < 1000);
		chk({30'h0, error_tally_valid}, 32'h0000_0003);
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// Sweep lengths, gaps between sweeps and the span of positions visited
	always @(posedge pclk) begin
		if (scan_busy === 1'b1) begin
			if (blen == 0 && lens.size() > 0) begin
				gaps.push_back(glen);
			end
			blen++;
			glen = 0;
			if ($signed(phase0_scan_pos) < mn0) mn0 = phase0_scan_pos;
			if ($signed(phase0_scan_pos) > mx0) mx0 = phase0_scan_pos;
			if ($signed(phase1_scan_pos) < mn1) mn1 = phase1_scan_pos;
			if ($signed(phase1_scan_pos) > mx1) mx1 = phase1_scan_pos;
		end else begin
			if (blen != 0) begin
				lens.push_back(blen);
			end
			blen = 0;
			glen++;
		end
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, HESC_OFF_DWELL, 32'h0000_0000);
		chk(rd, HESC_DWELL_RST);
		apb(1'b0, HESC_OFF_TUNE, 32'h0000_0000);
		chk(rd, {HESC_MASK_RST, 16'h0000});
		chk({27'h0, calc_precision}, {27'h0, HESC_PREC_FULL});
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0000_0000);
			chk(rd, rows[i].e);
		end
		chk({27'h0, calc_precision}, {27'h0, HESC_PREC_LESS});
		chk({16'h0, precision_mask}, 32'h0000_FFFE);
		chk({24'h0, sample_point_offset}, 32'h0000_00F6);
		chk({16'h0, phase1_scan_pos, phase0_scan_pos}, 32'h0000_FF00);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
		apb(1'b1, 8'h06, 32'h0000_0001);
		chk({31'h0, er}, 32'h0000_0001);
		// Single sweep; a second start in mid-sweep must change nothing
		mn0 = 127;
		mn1 = 127;
		mx0 = -128;
		mx1 = -128;
		apb(1'b1, HESC_OFF_CTRL, 32'h0000_0009);
		repeat (20) @(posedge pclk);
		apb(1'b1, HESC_OFF_CTRL, 32'h0000_0009);
		repeat (1200) @(posedge pclk);
		chk(lens.size(), 1);
		chk(lens[0], 128 * D);
		chk({mn0, mx0, mn1, mx1}, 32'h007F_80FF);
		chk({23'h0, aperture_result}, 32'(2 * EYE));
		apb(1'b0, HESC_OFF_STATUS, 32'h0000_0000);
		chk({23'h0, rd[16:8]}, 32'(2 * EYE));
		// Start with the controller off is ignored
		apb(1'b1, HESC_OFF_CTRL, 32'h0000_0008);
		repeat (20) @(posedge pclk);
		chk({31'h0, scan_busy}, 32'h0000_0000);
		// Continuous mode, stopped by clearing repeat during the second sweep
		lens.delete();
		gaps.delete();
		apb(1'b1, HESC_OFF_CTRL, 32'h0000_000B);
		k = 0;
		while (lens.size() < 1 && k < 2000) begin
			@(posedge pclk);
			k++;
		end
		apb(1'b1, HESC_OFF_CTRL, 32'h0000_0001);
		repeat (1200) @(posedge pclk);
		chk(lens.size(), 2);
		chk(gaps[0], 1);
		chk(lens[1], 128 * D);
		// Manual placement, moving each phase one step only
		apb(1'b1, HESC_OFF_MANUAL, 32'h0000_FE01);
		repeat (2) @(posedge pclk);
		chk({16'h0, phase1_scan_pos, phase0_scan_pos}, 32'h0000_FE01);
		noisy <= 1'b1;
		wait_valid();
		wait_valid();
		chk({18'h0, phase1_error_tally, phase0_error_tally}, 32'h0000_0204);
		@(posedge pclk);
		noisy <= 1'b0;
		wait_valid();
		wait_valid();
		chk({18'h0, phase1_error_tally, phase0_error_tally}, 32'h0000_0000);
		@(posedge pclk);
		noisy <= 1'b1;
		// Long window: the tally must stop at its ceiling rather than wrap
		apb(1'b1, HESC_OFF_DWELL, 32'h0000_00C8);
		wait_valid();
		wait_valid();
		chk({18'h0, phase1_error_tally, phase0_error_tally}, 32'h0000_3FFF);
		apb(1'b0, HESC_OFF_TALLY0, 32'h0000_0000);
		chk(rd, 32'h0000_007F);
		apb(1'b0, HESC_OFF_TALLY1, 32'h0000_0000);
		chk(rd, 32'h0000_007F);
		apb(1'b0, HESC_OFF_SCANPOS, 32'h0000_0000);
		chk(rd, 32'h0000_FE01);
		// Reset in mid-sweep clears busy, the aperture and the tuning back to defaults
		apb(1'b1, HESC_OFF_CTRL, 32'h0000_0009);
		repeat (2) @(posedge pclk);
		chk({31'h0, scan_busy}, 32'h0000_0001);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({31'h0, scan_busy}, 32'h0000_0000);
		chk({23'h0, aperture_result}, 32'h0000_0000);
		chk({16'h0, precision_mask}, {16'h0, HESC_MASK_RST});
		chk({27'h0, calc_precision}, {27'h0, HESC_PREC_FULL});
		chk({18'h0, phase1_error_tally, phase0_error_tally}, 32'h0000_0000);
		presetn <= 1'b1;
		apb(1'b0, HESC_OFF_DWELL, 32'h0000_0000);
		chk(rd, HESC_DWELL_RST);
		tally_and_finish();
	end
endmodule
`default_nettype wire
